// ==== rsr_pkg.sv ====
// rsr_pkg: constants and types for the run-time settings report block
// assumes: 32-bit classic wishbone, byte addresses, one clock domain
package rsr_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [11:0] ADR_CMD      = 12'h000;
  localparam logic [11:0] ADR_CHIP_SET = 12'h004;
  localparam logic [11:0] ADR_CLK_SET  = 12'h008;
  localparam logic [11:0] ADR_PIN_EN   = 12'h00c;
  localparam logic [11:0] ADR_STATUS   = 12'h010;
  localparam logic [3:0]  ADR_RPT_PAGE = 4'h1;

  // ==========================================================================
  // command codes and report bytes
  localparam logic [7:0] CMD_GET_SETTINGS = 8'h61;
  localparam logic [7:0] STS_OK           = 8'h00;
  localparam logic [5:0] BYTE_ECHO        = 6'h00;
  localparam logic [5:0] BYTE_STATUS      = 6'h01;
  localparam logic [5:0] BYTE_CHIP_LEN    = 6'h02;
  localparam logic [5:0] BYTE_GP_LEN      = 6'h03;
  localparam logic [5:0] BYTE_CHIP_SET    = 6'h04;
  localparam logic [5:0] BYTE_CLK_SET     = 6'h05;

  // ==========================================================================
  // chip settings byte fields
  localparam int unsigned BIT_SERIAL_EN  = 7;
  localparam int unsigned BIT_RX_IDLE    = 6;
  localparam int unsigned BIT_TX_IDLE    = 5;
  localparam int unsigned BIT_I2C_IDLE   = 4;
  localparam int unsigned BIT_SUSP_IDLE  = 3;
  localparam int unsigned BIT_CFG_IDLE   = 2;
  localparam int unsigned LOCK_MSB       = 1;
  localparam int unsigned LOCK_LSB       = 0;
  localparam logic [1:0]  LOCK_UNSECURED = 2'h0;
  localparam logic [1:0]  LOCK_PASSWORD  = 2'h1;
  localparam logic [1:0]  LOCK_PERMANENT = 2'h2;

  // clock-output field: duty in 4:3, ratio in 2:0
  localparam int unsigned CLK_DUTY_MSB  = 4;
  localparam int unsigned CLK_DUTY_LSB  = 3;
  localparam int unsigned CLK_RATIO_MSB = 2;
  localparam logic [1:0]  DUTY_QUARTER  = 2'h1;
  localparam logic [1:0]  DUTY_3QUARTER = 2'h2;

  // pin-function enable register fields
  localparam int unsigned EN_I2C  = 0;
  localparam int unsigned EN_SUSP = 1;
  localparam int unsigned EN_CFG  = 2;
  localparam int unsigned EN_CLK  = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_CHIP_SET = 8'h00;
  localparam logic [4:0] RST_CLK_SET  = 5'h00;
  localparam logic [3:0] RST_PIN_EN   = 4'h0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    RSR_IDLE,
    RSR_FILL
  } rsr_fsm_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rsr_wb_req_s;

  typedef struct packed {
    logic uart_rx_busy;
    logic uart_tx_busy;
    logic i2c_busy;
    logic usb_suspended;
    logic usb_configured;
  } rsr_activity_s;

  typedef struct packed {
    logic rx;
    logic tx;
    logic i2c;
    logic susp;
    logic cfg;
  } rsr_ind_s;

endpackage : rsr_pkg

// ==== rsr_report_mem.sv ====
// rsr_report_mem: report byte buffer, one write port, one registered read port
// assumes: single clock, write and read may hit the same word in one cycle
`timescale 1ns/100ps
`default_nettype none

module rsr_report_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = 6
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  // write port
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } rsr_mem_state_s;

  rsr_mem_state_s q;
  rsr_mem_state_s next_q;

  if (DEPTH > (1 << AW) || DEPTH < 6) begin : g_bad_depth
    $error("rsr_report_mem: depth does not fit address width");
  end

  always_comb begin
    next_q       = q;
    next_q.rdata = q.mem[rd_addr_in];
    if (wr_en_in) begin
      next_q.mem[wr_addr_in] = wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rd_data_out = q.rdata;

endmodule : rsr_report_mem

`default_nettype wire

// ==== rsr_top.sv ====
// rsr_top: builds the run-time settings report and drives the indicator pins
// assumes: classic wishbone master on ref_clk_in, activity inputs synchronous
//
// Notes on behaviour
// (RULE1) bytes 0,1 carry 0x61 echo and success
// (RULE2) bytes 2,3 give chip and pin area lengths
// (RULE3) byte 4 bit 7 is serial enumeration enable
// (RULE4) rx indicator inverts bit 6 while receiving
// (RULE5) tx indicator inverts bit 5 while sending
// (RULE6) i2c indicator inverts bit 4 when enabled, active
// (RULE7) suspend indicator inverts bit 3 in suspend; code inverts it only while pin_en bit EN_SUSP is set
// (RULE8) config-done indicator inverts bit 2 once configured; code inverts it only while pin_en bit EN_CFG is set
// (RULE9) byte 4 bits 1-0 give protection mode
// (RULE10) byte 5 bits 4-0 set clock-out duty, ratio
// (RULE11) host requests with code 0x61, rest zero
// (RULE12) report shows current settings, unused bits zero
`timescale 1ns/100ps
`default_nettype none

module rsr_top #(
  parameter int unsigned RPT_DEPTH     = 64,
  parameter logic [7:0]  CHIP_AREA_LEN = 8'h04,
  parameter logic [7:0]  GP_AREA_LEN   = 8'h04
) (
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  // wishbone slave
  input  wire rsr_pkg::rsr_wb_req_s  wb_req_in,
  output logic                       wb_ack_out,
  output logic [31:0]                wb_dat_out,
  // activity sources
  input  wire rsr_pkg::rsr_activity_s activity_in,
  // indicator and function pins
  output logic                       rx_activity_indicator_out,
  output logic                       tx_activity_indicator_out,
  output logic                       i2c_activity_indicator_out,
  output logic                       suspend_indicator_out,
  output logic                       enumeration_done_indicator_out,
  output logic                       general_purpose_pin_clk_out,
  // settings seen by the usb core
  output logic                       serial_number_enable_out,
  output logic [1:0]                 config_lock_mode_out,
  output logic                       report_done_out
);

  localparam int unsigned AW = 6;

  if (RPT_DEPTH > 64 || RPT_DEPTH < 6) begin : g_bad_depth
    $error("rsr_top: report depth must lie between 6 and 64");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    rsr_pkg::rsr_fsm_e fsm;
    logic [AW-1:0]     idx;
    logic [7:0]        chip;
    logic [4:0]        clkset;
    logic [3:0]        pin_en;
    logic [7:0]        snap_chip;
    logic [4:0]        snap_clk;
    logic              done;
    logic              bad_cmd;
    logic [7:0]        last_cmd;
    logic [7:0]        ccnt;
    logic              clk_pin;
    logic              rd_pend;
    logic              ack;
    logic [31:0]       dat;
    rsr_pkg::rsr_ind_s ind;
  } rsr_state_s;

  localparam rsr_state_s RST_STATE = '{
    fsm:       rsr_pkg::RSR_IDLE,
    idx:       '0,
    chip:      rsr_pkg::RST_CHIP_SET,
    clkset:    rsr_pkg::RST_CLK_SET,
    pin_en:    rsr_pkg::RST_PIN_EN,
    snap_chip: rsr_pkg::RST_CHIP_SET,
    snap_clk:  rsr_pkg::RST_CLK_SET,
    done:      1'b0,
    bad_cmd:   1'b0,
    last_cmd:  8'h00,
    ccnt:      8'h00,
    clk_pin:   1'b0,
    rd_pend:   1'b0,
    ack:       1'b0,
    dat:       32'h0000_0000,
    ind:       '0
  };

  rsr_state_s    q;
  rsr_state_s    next_q;
  logic [7:0]    mem_rdata;
  logic          mem_wr_en;
  logic [7:0]    mem_wr_data;
  logic [AW-1:0] mem_rd_addr;

  // ==========================================================================
  // functions
  function automatic logic [7:0] report_byte(
    input logic [AW-1:0] idx,
    input logic [7:0]    chip,
    input logic [4:0]    clkset
  );
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      rsr_pkg::BYTE_ECHO:     b = rsr_pkg::CMD_GET_SETTINGS;  // [RULE1]
      rsr_pkg::BYTE_STATUS:   b = rsr_pkg::STS_OK;            // [RULE1]
      rsr_pkg::BYTE_CHIP_LEN: b = CHIP_AREA_LEN;              // [RULE2]
      rsr_pkg::BYTE_GP_LEN:   b = GP_AREA_LEN;                // [RULE2]
      rsr_pkg::BYTE_CHIP_SET: b = chip;                       // [RULE3] [RULE9]
      rsr_pkg::BYTE_CLK_SET:  b = {3'h0, clkset};             // [RULE10] [RULE12]
      default:                b = 8'h00;
    endcase
    return b;
  endfunction : report_byte

  // high time of the divided clock, in cycles of the period 2 << ratio
  function automatic logic [7:0] clk_high_time(input logic [4:0] clkset);
    logic [8:0] half;
    logic [8:0] hi;
    half = 9'h001 << clkset[rsr_pkg::CLK_RATIO_MSB:0];
    case (clkset[rsr_pkg::CLK_DUTY_MSB:rsr_pkg::CLK_DUTY_LSB])
      rsr_pkg::DUTY_QUARTER:  hi = half >> 1;
      rsr_pkg::DUTY_3QUARTER: hi = half + (half >> 1);
      default:                hi = half;
    endcase
    return hi[7:0];
  endfunction : clk_high_time

  // period of the divided clock less one, in clock cycles
  function automatic logic [7:0] clk_period_m1(input logic [4:0] clkset);
    logic [8:0] per;
    per = 9'h002 << clkset[rsr_pkg::CLK_RATIO_MSB:0];
    return 8'(per - 9'h001);
  endfunction : clk_period_m1

  // pin level: idle value, inverted while its event is active
  function automatic logic ind_level(
    input logic idle,
    input logic active
  );
    return idle ^ active;
  endfunction : ind_level

  // report window: one pending cycle for the buffer read
  function automatic logic in_report_page(input logic [11:0] adr);
    return adr[11:8] == rsr_pkg::ADR_RPT_PAGE;
  endfunction : in_report_page

  // taken write that carries the low byte lane
  function automatic logic low_lane_write(
    input logic                 req,
    input rsr_pkg::rsr_wb_req_s r
  );
    return req && r.we && r.sel[0];
  endfunction : low_lane_write

  // register read data; unmapped offsets read zero
  function automatic logic [31:0] reg_read_data(
    input rsr_state_s  s,
    input logic [11:0] adr
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    case (adr)
      rsr_pkg::ADR_CMD: begin
        d = {21'h00_0000, s.fsm == rsr_pkg::RSR_FILL, s.bad_cmd, s.done, s.last_cmd};
      end
      rsr_pkg::ADR_CHIP_SET: begin
        d = {24'h00_0000, s.chip};
      end
      rsr_pkg::ADR_CLK_SET: begin
        d = {27'h000_0000, s.clkset};
      end
      rsr_pkg::ADR_PIN_EN: begin
        d = {28'h000_0000, s.pin_en};
      end
      rsr_pkg::ADR_STATUS: begin
        d = {26'h000_0000, s.clk_pin, s.ind};
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction : reg_read_data

  // ==========================================================================
  // next state
  always_comb begin
    logic        req;
    logic        wr;
    logic [7:0]  period_m1;
    logic [7:0]  hi;
    logic [31:0] rdat;
    req       = 1'b0;
    wr        = 1'b0;
    period_m1 = 8'h00;
    hi        = 8'h00;
    rdat      = 32'h0000_0000;
    next_q    = q;
    next_q.ack = 1'b0;

    req = wb_req_in.cyc && wb_req_in.stb && !q.ack && !q.rd_pend;
    wr  = low_lane_write(req, wb_req_in);

    // report fill, one byte a cycle from the snapshot
    if (q.fsm == rsr_pkg::RSR_FILL) begin
      if (q.idx == AW'(RPT_DEPTH - 1)) begin
        next_q.fsm  = rsr_pkg::RSR_IDLE;
        next_q.done = 1'b1;
      end else begin
        next_q.idx = q.idx + AW'(1);
      end
    end

    // bus access
    if (q.rd_pend) begin
      next_q.rd_pend = 1'b0;
      next_q.ack     = 1'b1;
      next_q.dat     = {24'h00_0000, mem_rdata};
    end else if (req && in_report_page(wb_req_in.adr)) begin
      if (wb_req_in.we) begin
        next_q.ack = 1'b1;
        next_q.dat = 32'h0000_0000;
      end else begin
        next_q.rd_pend = 1'b1;
      end
    end else if (req) begin
      next_q.ack = 1'b1;
      case (wb_req_in.adr)
        rsr_pkg::ADR_CMD: begin
          if (wr && q.fsm == rsr_pkg::RSR_IDLE) begin
            next_q.last_cmd = wb_req_in.dat[7:0];
            if (wb_req_in.dat[7:0] == rsr_pkg::CMD_GET_SETTINGS) begin  // [RULE11]
              next_q.fsm       = rsr_pkg::RSR_FILL;
              next_q.idx       = '0;
              next_q.done      = 1'b0;
              next_q.bad_cmd   = 1'b0;
              next_q.snap_chip = q.chip;    // [RULE12]
              next_q.snap_clk  = q.clkset;  // [RULE12]
            end else begin
              next_q.bad_cmd = 1'b1;
            end
          end
        end
        rsr_pkg::ADR_CHIP_SET: begin
          if (wr) begin
            next_q.chip = wb_req_in.dat[7:0];  // [RULE12]
          end
        end
        rsr_pkg::ADR_CLK_SET: begin
          if (wr) begin
            next_q.clkset = wb_req_in.dat[4:0];  // [RULE10]
          end
        end
        rsr_pkg::ADR_PIN_EN: begin
          if (wr) begin
            next_q.pin_en = wb_req_in.dat[3:0];
          end
        end
        rsr_pkg::ADR_STATUS: begin
          // read only
        end
        default: begin
          // unmapped offsets: acked, writes dropped
        end
      endcase
      rdat       = reg_read_data(q, wb_req_in.adr);
      next_q.dat = wb_req_in.we ? 32'h0000_0000 : rdat;
    end

    // indicator pins: idle level, inverted while the event is active; i2c, suspend and config-done only when enabled in pin_en
    next_q.ind.rx   = ind_level(q.chip[rsr_pkg::BIT_RX_IDLE], activity_in.uart_rx_busy);  // [RULE4]
    next_q.ind.tx   = ind_level(q.chip[rsr_pkg::BIT_TX_IDLE], activity_in.uart_tx_busy);  // [RULE5]
    next_q.ind.i2c  = ind_level(q.chip[rsr_pkg::BIT_I2C_IDLE],
                                activity_in.i2c_busy && q.pin_en[rsr_pkg::EN_I2C]);  // [RULE6]
    next_q.ind.susp = ind_level(q.chip[rsr_pkg::BIT_SUSP_IDLE],
                                activity_in.usb_suspended && q.pin_en[rsr_pkg::EN_SUSP]);  // [RULE7]
    next_q.ind.cfg  = ind_level(q.chip[rsr_pkg::BIT_CFG_IDLE],
                                activity_in.usb_configured && q.pin_en[rsr_pkg::EN_CFG]);  // [RULE8]

    // divided clock on the general-purpose pin
    period_m1 = clk_period_m1(q.clkset);                                      // [RULE10]
    hi        = clk_high_time(q.clkset);                                      // [RULE10]
    if (!q.pin_en[rsr_pkg::EN_CLK] || q.ccnt >= period_m1) begin
      next_q.ccnt = 8'h00;
    end else begin
      next_q.ccnt = q.ccnt + 8'h01;
    end
    next_q.clk_pin = q.pin_en[rsr_pkg::EN_CLK] && (next_q.ccnt < hi);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= RST_STATE;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // report buffer
  assign mem_wr_en   = (q.fsm == rsr_pkg::RSR_FILL);
  assign mem_wr_data = report_byte(q.idx, q.snap_chip, q.snap_clk);  // [RULE1] [RULE2]
  assign mem_rd_addr = wb_req_in.adr[AW+1:2];

  rsr_report_mem #(
    .WIDTH (8),
    .DEPTH (RPT_DEPTH),
    .AW    (AW)
  ) u_report_mem (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (mem_wr_en),
    .wr_addr_in  (q.idx),
    .wr_data_in  (mem_wr_data),
    .rd_addr_in  (mem_rd_addr),
    .rd_data_out (mem_rdata)
  );

  // ==========================================================================
  // outputs, all from flip-flops
  assign wb_ack_out                     = q.ack;
  assign wb_dat_out                     = q.dat;
  assign rx_activity_indicator_out      = q.ind.rx;
  assign tx_activity_indicator_out      = q.ind.tx;
  assign i2c_activity_indicator_out     = q.ind.i2c;
  assign suspend_indicator_out          = q.ind.susp;
  assign enumeration_done_indicator_out = q.ind.cfg;
  assign general_purpose_pin_clk_out    = q.clk_pin;
  assign serial_number_enable_out       = q.chip[rsr_pkg::BIT_SERIAL_EN];                   // [RULE3]
  assign config_lock_mode_out           = q.chip[rsr_pkg::LOCK_MSB:rsr_pkg::LOCK_LSB];      // [RULE9]
  assign report_done_out                = q.done;

endmodule : rsr_top

`default_nettype wire

// ==== rsr_top_props.sv ====
// rsr_top_props: port-level checks of the settings report block
// assumes: bound onto rsr_top, one clock, reset active low
`timescale 1ns/100ps
`default_nettype none

module rsr_top_props (
  // clock and reset
  input wire logic                   ref_clk_in,
  input wire logic                   rstn_in,
  // bus
  input wire rsr_pkg::rsr_wb_req_s   wb_req_in,
  input wire logic                   wb_ack_out,
  input wire logic [31:0]            wb_dat_out,
  // pins
  input wire rsr_pkg::rsr_activity_s activity_in,
  input wire logic                   rx_activity_indicator_out,
  input wire logic                   tx_activity_indicator_out,
  input wire logic                   serial_number_enable_out,
  input wire logic [1:0]             config_lock_mode_out,
  input wire logic                   report_done_out
);
  // ==========================================================================
  // helpers
  logic cmd_go;
  assign cmd_go = wb_ack_out & wb_req_in.we & wb_req_in.sel[0] & (wb_req_in.adr == rsr_pkg::ADR_CMD)
                  & (wb_req_in.dat[7:0] == rsr_pkg::CMD_GET_SETTINGS);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // ==========================================================================
  // assertions
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  reg_latency_a: assert property ($rose(wb_req_in.stb) && wb_req_in.cyc
    && (wb_req_in.adr[11:8] != rsr_pkg::ADR_RPT_PAGE || wb_req_in.we)
    |=> wb_ack_out) else $error("register access not acked after one cycle");
  rpt_latency_a: assert property ($rose(wb_req_in.stb) && wb_req_in.cyc
    && wb_req_in.adr[11:8] == rsr_pkg::ADR_RPT_PAGE && !wb_req_in.we |=> !wb_ack_out ##1 wb_ack_out)
    else $error("report read not acked after two cycles");
  unused_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:11] == 21'h0
    && (!wb_req_in.we || wb_dat_out == 32'h0)) else $error("unused data bits not zero");
  rx_follow_a: assert property ($changed(activity_in.uart_rx_busy) && !wb_ack_out
    |=> $changed(rx_activity_indicator_out)) else $error("rx indicator ignored activity");
  tx_follow_a: assert property ($changed(activity_in.uart_tx_busy) && !wb_ack_out
    |=> $changed(tx_activity_indicator_out)) else $error("tx indicator ignored activity");
  serial_hold_a: assert property ($changed(serial_number_enable_out)
    |-> wb_ack_out || $past(wb_ack_out)) else $error("serial enable changed without a write");
  lock_hold_a: assert property ($changed(config_lock_mode_out)
    |-> wb_ack_out || $past(wb_ack_out)) else $error("lock mode changed without a write");
  report_done_a: assert property (cmd_go |-> ##[1:70] report_done_out)
    else $error("report not complete in time");

  // ==========================================================================
  // covers
  cover property (cmd_go ##[1:70] $rose(report_done_out));
  cover property ($rose(wb_req_in.stb) && wb_req_in.adr[11:8] == rsr_pkg::ADR_RPT_PAGE);
  cover property ($changed(rx_activity_indicator_out));
endmodule : rsr_top_props

bind rsr_top rsr_top_props u_rsr_top_props (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out),
  .wb_dat_out(wb_dat_out), .activity_in(activity_in), .rx_activity_indicator_out(rx_activity_indicator_out),
  .tx_activity_indicator_out(tx_activity_indicator_out), .serial_number_enable_out(serial_number_enable_out),
  .config_lock_mode_out(config_lock_mode_out), .report_done_out(report_done_out));

`default_nettype wire

// ==== rsr_host_model.sv ====
// rsr_host_model: host side, issues classic wishbone cycles and commands
// assumes: slave acks within the bench watchdog span
`timescale 1ns/100ps
`default_nettype none

module rsr_host_model (
  // clock
  input wire logic                 ref_clk_in,
  // bus
  input wire logic                 wb_ack_in,
  input wire logic [31:0]          wb_dat_in,
  output var rsr_pkg::rsr_wb_req_s wb_req_out
);
  initial wb_req_out = '0;

  task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                          output logic [31:0] rdat);
    @(posedge ref_clk_in);
    wb_req_out <= {1'b1, 1'b1, we, adr, 4'h1, dat};
    do @(posedge ref_clk_in); while (wb_ack_in !== 1'b1);
    rdat = wb_dat_in;
    wb_req_out <= '0;
  endtask : wb_cycle

  task automatic wb_write(input logic [11:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    wb_cycle(1'b1, adr, dat, unused);
  endtask : wb_write

  task automatic wb_read(input logic [11:0] adr, output logic [31:0] dat);
    wb_cycle(1'b0, adr, 32'h0, dat);
  endtask : wb_read

  // request code first, all other bytes zero
  task automatic get_settings;
    wb_write(rsr_pkg::ADR_CMD, {24'h0, rsr_pkg::CMD_GET_SETTINGS});
  endtask : get_settings
endmodule : rsr_host_model

`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for the settings report block
// assumes: host model drives the bus, bench drives activity levels
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam logic [7:0] LEN_C = 8'h0a;
  localparam logic [7:0] LEN_G = 8'h0c;
  logic                   clk  = 1'b0;
  logic                   rstn = 1'b0;
  rsr_pkg::rsr_wb_req_s   req;
  rsr_pkg::rsr_activity_s act  = '0;
  logic                   ack, rx_i, tx_i, i2c_i, susp_i, cfg_i, gp_clk, ser_en, done;
  logic [31:0]            rdat, rd;
  logic [1:0]             lock;
  int                     err_total = 0;
  int                     total_checks = 0;
  int                     chip, clks, pen, n, h, l, per, exp_h, seed_v;

  always #12.5 clk = ~clk;

  rsr_top #(.RPT_DEPTH(64), .CHIP_AREA_LEN(LEN_C), .GP_AREA_LEN(LEN_G)) u_rsr_top (
    .ref_clk_in(clk), .rstn_in(rstn), .wb_req_in(req), .wb_ack_out(ack), .wb_dat_out(rdat),
    .activity_in(act), .rx_activity_indicator_out(rx_i), .tx_activity_indicator_out(tx_i),
    .i2c_activity_indicator_out(i2c_i), .suspend_indicator_out(susp_i),
    .enumeration_done_indicator_out(cfg_i), .general_purpose_pin_clk_out(gp_clk),
    .serial_number_enable_out(ser_en), .config_lock_mode_out(lock), .report_done_out(done));
  rsr_host_model u_rsr_host_model (.ref_clk_in(clk), .wb_ack_in(ack), .wb_dat_in(rdat), .wb_req_out(req));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================================
  // reference model
  function automatic logic [7:0] rpt_byte(input int i);
    case (i)
      0: return rsr_pkg::CMD_GET_SETTINGS;
      1: return rsr_pkg::STS_OK;
      2: return LEN_C;
      3: return LEN_G;
      4: return chip[7:0];
      5: return {3'h0, clks[4:0]};
      default: return 8'h00;
    endcase
  endfunction : rpt_byte

  task automatic chk_pins;
    logic [4:0] e;
    e = {chip[6] ^ act.uart_rx_busy, chip[5] ^ act.uart_tx_busy, chip[4] ^ (act.i2c_busy & pen[0]),
         chip[3] ^ (act.usb_suspended & pen[1]), chip[2] ^ (act.usb_configured & pen[2])};
    chk({27'h0, rx_i, tx_i, i2c_i, susp_i, cfg_i}, {27'h0, e});
    u_rsr_host_model.wb_read(rsr_pkg::ADR_STATUS, rd);
    chk({27'h0, rd[4:0]}, {27'h0, e});
  endtask : chk_pins

  task automatic clk_check(input int duty, input int ratio);
    per = 2 << ratio;
    exp_h = (duty == 1) ? per / 4 : (duty == 2) ? 3 * per / 4 : per / 2;
    n = 0;
    while (gp_clk !== 1'b0 && n < 600) begin @(posedge clk); n++; end
    while (gp_clk !== 1'b1 && n < 600) begin @(posedge clk); n++; end
    h = 0;
    while (gp_clk === 1'b1 && h < 600) begin @(posedge clk); h++; end
    l = 0;
    while (gp_clk === 1'b0 && l < 600) begin @(posedge clk); l++; end
    chk(h, exp_h);
    chk(h + l, per);
  endtask : clk_check

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // tests
  initial begin
    seed_v = $urandom(32'hdac0);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    chip = 0;
    clks = 0;
    pen = 0;
    u_rsr_host_model.wb_read(rsr_pkg::ADR_CHIP_SET, rd);
    chk(rd, 32'h0);
    u_rsr_host_model.wb_read(rsr_pkg::ADR_CLK_SET, rd);
    chk(rd, 32'h0);
    u_rsr_host_model.wb_write(12'h0f0, 32'hff);
    u_rsr_host_model.wb_read(12'h0f0, rd);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      chip = ($urandom_range(63, 0) << 2) | (i % 3);
      clks = (i << 3) | $urandom_range(4, 2);
      pen = $urandom_range(7, 0) | 8;
      u_rsr_host_model.wb_write(rsr_pkg::ADR_CHIP_SET, chip);
      u_rsr_host_model.wb_write(rsr_pkg::ADR_CLK_SET, clks | 32'he0);
      u_rsr_host_model.wb_write(rsr_pkg::ADR_PIN_EN, pen);
      u_rsr_host_model.wb_read(rsr_pkg::ADR_CHIP_SET, rd);
      chk(rd, chip);
      u_rsr_host_model.wb_read(rsr_pkg::ADR_CLK_SET, rd);
      chk(rd, clks);
      chk({30'h0, lock}, i % 3);
      chk({31'h0, ser_en}, chip[7]);
      u_rsr_host_model.wb_write(rsr_pkg::ADR_CMD, 32'h55);
      u_rsr_host_model.wb_read(rsr_pkg::ADR_CMD, rd);
      chk({31'h0, rd[9]}, 32'h1);
      u_rsr_host_model.get_settings();
      n = 0;
      while (done !== 1'b1 && n < 200) begin @(posedge clk); n++; end
      chk({31'h0, done}, 32'h1);
      u_rsr_host_model.wb_write(12'h104, 32'hff);
      for (int b = 0; b < 8; b++) begin
        u_rsr_host_model.wb_read(12'h100 + 12'(4 * b), rd);
        chk(rd, {24'h0, rpt_byte(b)});
      end
      u_rsr_host_model.wb_read(rsr_pkg::ADR_CMD, rd);
      chk({21'h0, rd[10:0]}, {21'h0, 3'b001, rsr_pkg::CMD_GET_SETTINGS});
      for (int k = 0; k < 4; k++) begin
        act <= 5'($urandom_range(31, 0));
        repeat (2) @(posedge clk);
        chk_pins();
      end
      clk_check(i, clks & 7);
      $display("test %0d done", i);
    end
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
